// File: inc/spmhd_defs.svh
// Constants for the switch port half-duplex MAC control block
// Functional notes
// - Collision control register holds no-excessive-collision-drop option, cleared at reset.
// - MAC control bit 7 selects the alternate collision back-off algorithm.
// - MAC control registers accept SPI, I2C, in-band writes; MII management writes refused.
// - MAC control bit 3 enables the ingress length field check.
// - With the check on, frames whose length field mismatches data length are dropped.
// - Only frames carrying a length field are checked; type field frames pass.
// - Collisions after the first 512 bit times of transmission are late collisions.
// - Each port counts transmit late collisions, readable at counter index 0x16.
// - Each port keeps its own duplex, collision and transmit state.
`ifndef SPMHD_DEFS_SVH
`define SPMHD_DEFS_SVH
`define SPMHD_COLL_CTRL_ADDR 16'h0300
`define SPMHD_MAC_CTRL0_ADDR 16'h0330
`define SPMHD_MIB_LATE_COL_IDX 16'h0016
`define SPMHD_COLL_CTRL_RST 8'h00
`define SPMHD_MAC_CTRL0_RST 8'h00
`define SPMHD_NO_EXC_DROP_BIT 0
`define SPMHD_ALT_BACKOFF_BIT 7
`define SPMHD_LEN_CHECK_BIT 3
`define SPMHD_SLOT_BITS 11'h0200
`define SPMHD_ATTEMPT_LIMIT 5'h10
`define SPMHD_BACKOFF_LIMIT 5'h0A
`define SPMHD_MAX_LEN_FIELD 11'h05DC
`define SPMHD_MIN_DATA 11'h002E
`define SPMHD_HDR_FCS_BYTES 11'h0012
`define SPMHD_TAIL_TAG_BYTES 11'h0001
`define SPMHD_LEN_HI_POS 11'h000C
`define SPMHD_LEN_LO_POS 11'h000D
`define SPMHD_DEF_SEED 16'hACE1
`define SPMHD_ALT_SEED 16'h5A3C
`define SPMHD_VERD_DROP_BIT 11
`endif

// File: inc/spmhd_pkg.sv
// Types for the switch port half-duplex MAC control block
`default_nettype none
package spmhd_pkg;
  typedef enum logic [1:0] {
    SPMHD_SRC_SPI,
    SPMHD_SRC_I2C,
    SPMHD_SRC_INBAND,
    SPMHD_SRC_MIIM
  } spmhd_src_e;
  typedef enum logic [1:0] {
    SPMHD_TX_IDLE,
    SPMHD_TX_XMIT,
    SPMHD_TX_BACKOFF
  } spmhd_tx_e;
  typedef logic [11:0] spmhd_verd_t;
endpackage : spmhd_pkg
`default_nettype wire

// File: rtl/spmhd_port.sv
// One switch port: half-duplex collision handling, back-off, ingress length check
`include "spmhd_defs.svh"
`default_nettype none
module spmhd_port (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Management access
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic mgmt_mib,
  input wire spmhd_pkg::spmhd_src_e mgmt_src,
  input wire logic [15:0] mgmt_addr,
  input wire logic [7:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata_r,
  output logic mgmt_rvalid_r,
  output logic mgmt_refused_r,
  // Port configuration
  input wire logic half_duplex,
  input wire logic tail_tag_en,
  // Transmit control
  input wire logic tx_req,
  input wire logic tx_done,
  input wire logic bit_tick,
  input wire logic col_pin,
  output logic tx_active_r,
  output logic tx_abort_r,
  output logic tx_drop_r,
  output logic tx_ok_r,
  // Receive stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_sop,
  input wire logic rx_eop,
  output logic rx_ready_r,
  // Frame verdicts
  output logic verd_valid_r,
  output spmhd_pkg::spmhd_verd_t verd_data_r,
  input wire logic verd_ready
);
  import spmhd_pkg::*;

  logic [7:0] coll_ctrl_r;
  logic [7:0] mac_ctrl0_r;
  logic [15:0] late_cnt_r;
  logic wr_ok;
  logic col_s1_r, col_s2_r, col_s3_r, col_f_r;
  spmhd_tx_e tx_st_r;
  logic [10:0] bit_cnt_r;
  logic [9:0] slot_cnt_r;
  logic [4:0] attempts_r;
  logic [15:0] lfsr_def_r, lfsr_alt_r;
  logic [15:0] draw;
  logic [9:0] mask;
  logic col_hit, late_hit;
  logic [10:0] byte_cnt_r;
  logic [15:0] len_field_r;
  logic [10:0] total, meas, expect_len;
  logic is_len, drop_calc, eop_acc, pop;
  spmhd_verd_t verd_new, ent1_r;
  logic [1:0] cnt_r, cnt_nxt;

  // Register writes; MII management path may not write
  assign wr_ok = ce && mgmt_wr && !mgmt_mib && (mgmt_src != SPMHD_SRC_MIIM);
  always_ff @(posedge clk) begin
    if (rst) begin
      coll_ctrl_r <= `SPMHD_COLL_CTRL_RST;
      mac_ctrl0_r <= `SPMHD_MAC_CTRL0_RST;
    end else if (wr_ok) begin
      if (mgmt_addr == `SPMHD_COLL_CTRL_ADDR) coll_ctrl_r <= mgmt_wdata;
      if (mgmt_addr == `SPMHD_MAC_CTRL0_ADDR) mac_ctrl0_r <= mgmt_wdata;
    end
  end

  // Register and counter reads, refusal flag
  always_ff @(posedge clk) begin
    if (rst) begin
      mgmt_rdata_r <= 16'h0000;
      mgmt_rvalid_r <= 1'b0;
      mgmt_refused_r <= 1'b0;
    end else if (ce) begin
      mgmt_rvalid_r <= mgmt_rd;
      mgmt_refused_r <= mgmt_wr && (mgmt_src == SPMHD_SRC_MIIM);
      if (mgmt_rd) begin
        if (mgmt_mib && mgmt_addr == `SPMHD_MIB_LATE_COL_IDX) mgmt_rdata_r <= late_cnt_r;
        else if (!mgmt_mib && mgmt_addr == `SPMHD_COLL_CTRL_ADDR)
          mgmt_rdata_r <= {8'h00, coll_ctrl_r};
        else if (!mgmt_mib && mgmt_addr == `SPMHD_MAC_CTRL0_ADDR)
          mgmt_rdata_r <= {8'h00, mac_ctrl0_r};
        else mgmt_rdata_r <= 16'h0000;
      end
    end
  end

  // Collision pin synchroniser and agreement filter
  always_ff @(posedge clk) begin
    if (rst) begin
      col_s1_r <= 1'b0;
      col_s2_r <= 1'b0;
      col_s3_r <= 1'b0;
      col_f_r <= 1'b0;
    end else if (ce) begin
      col_s1_r <= col_pin;
      col_s2_r <= col_s1_r;
      col_s3_r <= col_s2_r;
      if (col_s2_r == col_s3_r) col_f_r <= col_s3_r;
    end
  end

  // Two free-running back-off sequences with distinct taps and seeds
  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr_def_r <= `SPMHD_DEF_SEED;
      lfsr_alt_r <= `SPMHD_ALT_SEED;
    end else if (ce) begin
      lfsr_def_r <= {lfsr_def_r[14:0],
        lfsr_def_r[15] ^ lfsr_def_r[13] ^ lfsr_def_r[12] ^ lfsr_def_r[10]};
      lfsr_alt_r <= {lfsr_alt_r[14:0],
        lfsr_alt_r[15] ^ lfsr_alt_r[14] ^ lfsr_alt_r[12] ^ lfsr_alt_r[3]};
    end
  end

  // Collision classification and back-off slot draw
  always_comb begin
    draw = mac_ctrl0_r[`SPMHD_ALT_BACKOFF_BIT] ? lfsr_alt_r : lfsr_def_r;
    if (attempts_r >= `SPMHD_BACKOFF_LIMIT - 5'h01) mask = 10'h3FF;
    else mask = 10'((11'h002 << attempts_r) - 11'h001); // Nth hit: 0 to 2^n - 1
    col_hit = ce && half_duplex && col_f_r && (tx_st_r == SPMHD_TX_XMIT);
    late_hit = col_hit && (bit_cnt_r >= `SPMHD_SLOT_BITS);
  end

  // Late collision statistics, saturating
  always_ff @(posedge clk) begin
    if (rst) late_cnt_r <= 16'h0000;
    else if (late_hit && late_cnt_r != 16'hFFFF) late_cnt_r <= late_cnt_r + 16'h0001;
  end

  // Transmit state: transmit, collide, back off, retry or drop
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_st_r <= SPMHD_TX_IDLE;
      bit_cnt_r <= 11'h000;
      slot_cnt_r <= 10'h000;
      attempts_r <= 5'h00;
      tx_abort_r <= 1'b0;
      tx_drop_r <= 1'b0;
      tx_ok_r <= 1'b0;
      tx_active_r <= 1'b0;
    end else if (ce) begin
      tx_abort_r <= 1'b0;
      tx_drop_r <= 1'b0;
      tx_ok_r <= 1'b0;
      unique case (tx_st_r)
        SPMHD_TX_IDLE: begin
          bit_cnt_r <= 11'h000;
          if (tx_req) begin
            tx_st_r <= SPMHD_TX_XMIT;
            tx_active_r <= 1'b1;
          end
        end
        SPMHD_TX_XMIT: begin
          if (bit_tick && bit_cnt_r < `SPMHD_SLOT_BITS) bit_cnt_r <= bit_cnt_r + 11'h001;
          if (late_hit) begin
            tx_st_r <= SPMHD_TX_IDLE;
            tx_drop_r <= 1'b1;
            tx_active_r <= 1'b0;
            attempts_r <= 5'h00;
          end else if (col_hit) begin
            tx_abort_r <= 1'b1;
            tx_active_r <= 1'b0;
            if (attempts_r + 5'h01 >= `SPMHD_ATTEMPT_LIMIT &&
                !coll_ctrl_r[`SPMHD_NO_EXC_DROP_BIT]) begin
              tx_st_r <= SPMHD_TX_IDLE;
              tx_drop_r <= 1'b1;
              attempts_r <= 5'h00;
            end else begin
              tx_st_r <= SPMHD_TX_BACKOFF;
              attempts_r <= (attempts_r + 5'h01 >= `SPMHD_ATTEMPT_LIMIT) ? 5'h00 :
                attempts_r + 5'h01;
              slot_cnt_r <= draw[9:0] & mask;
              bit_cnt_r <= 11'h000;
            end
          end else if (tx_done) begin
            tx_st_r <= SPMHD_TX_IDLE;
            tx_ok_r <= 1'b1;
            tx_active_r <= 1'b0;
            attempts_r <= 5'h00;
          end
        end
        SPMHD_TX_BACKOFF: begin
          if (slot_cnt_r == 10'h000) begin
            tx_st_r <= SPMHD_TX_XMIT;
            tx_active_r <= 1'b1;
            bit_cnt_r <= 11'h000;
          end else if (bit_tick) begin
            if (bit_cnt_r == `SPMHD_SLOT_BITS - 11'h001) begin
              bit_cnt_r <= 11'h000;
              slot_cnt_r <= slot_cnt_r - 10'h001;
            end else bit_cnt_r <= bit_cnt_r + 11'h001;
          end
        end
      endcase
    end
  end

  // Ingress length measurement and verdict
  always_comb begin
    eop_acc = ce && rx_valid && rx_ready_r && rx_eop;
    pop = ce && verd_valid_r && verd_ready;
    total = (rx_sop ? 11'h000 : byte_cnt_r) + 11'h001;
    meas = total - `SPMHD_HDR_FCS_BYTES - (tail_tag_en ? `SPMHD_TAIL_TAG_BYTES : 11'h000);
    is_len = len_field_r <= {5'h00, `SPMHD_MAX_LEN_FIELD};
    expect_len = (len_field_r[10:0] < `SPMHD_MIN_DATA) ? `SPMHD_MIN_DATA : len_field_r[10:0];
    drop_calc = mac_ctrl0_r[`SPMHD_LEN_CHECK_BIT] && is_len && (meas != expect_len);
    verd_new = {drop_calc, meas};
    cnt_nxt = cnt_r + {1'b0, eop_acc} - {1'b0, pop};
  end

  // Byte position and length field capture
  always_ff @(posedge clk) begin
    if (rst) begin
      byte_cnt_r <= 11'h000;
      len_field_r <= 16'h0000;
    end else if (ce && rx_valid && rx_ready_r) begin
      byte_cnt_r <= rx_eop ? 11'h000 : (rx_sop ? 11'h001 : byte_cnt_r + 11'h001);
      if (!rx_sop && byte_cnt_r == `SPMHD_LEN_HI_POS) len_field_r[15:8] <= rx_data;
      if (!rx_sop && byte_cnt_r == `SPMHD_LEN_LO_POS) len_field_r[7:0] <= rx_data;
    end
  end

  // Two-entry verdict buffer; head entry drives the outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 2'h0;
      verd_valid_r <= 1'b0;
      verd_data_r <= 12'h000;
      ent1_r <= 12'h000;
      rx_ready_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      verd_valid_r <= cnt_nxt != 2'h0;
      rx_ready_r <= cnt_nxt != 2'h2;
      if (pop) begin
        if (cnt_r == 2'h2) begin
          verd_data_r <= ent1_r;
          if (eop_acc) ent1_r <= verd_new;
        end else if (eop_acc) verd_data_r <= verd_new;
      end else if (eop_acc) begin
        if (cnt_r == 2'h0) verd_data_r <= verd_new;
        else ent1_r <= verd_new;
      end
    end
  end

  // Checks on the block's own behaviour
  miim_refuse_a: assert property (@(posedge clk) disable iff (rst)
    mgmt_wr && mgmt_src == SPMHD_SRC_MIIM |=> $stable(coll_ctrl_r) && $stable(mac_ctrl0_r))
    else $error("MII management write changed a control register");
  opt_reset_a: assert property (@(posedge clk) rst |=> !coll_ctrl_r[0])
    else $error("No-drop option not cleared by reset");
  late_count_a: assert property (@(posedge clk) disable iff (rst)
    late_hit && late_cnt_r != 16'hFFFF |=> late_cnt_r == $past(late_cnt_r) + 16'h0001)
    else $error("Late collision not counted");
  early_col_a: assert property (@(posedge clk) disable iff (rst)
    col_hit && bit_cnt_r < 11'h200 |=> $stable(late_cnt_r) && tx_abort_r)
    else $error("Early collision misclassified");
  alt_seq_a: assert property (@(posedge clk) disable iff (rst || !ce)
    lfsr_def_r == lfsr_alt_r |-> ##[1:32] lfsr_def_r != lfsr_alt_r)
    else $error("Back-off sequences stay in step");
  alt_select_a: assert property (@(posedge clk) disable iff (rst)
    col_hit && !late_hit && mac_ctrl0_r[7] && tx_st_r == SPMHD_TX_XMIT && attempts_r == 5'h0
    |=> slot_cnt_r == ($past(lfsr_alt_r[9:0]) & 10'h001))
    else $error("Alternate back-off not used");
  def_select_a: assert property (@(posedge clk) disable iff (rst)
    col_hit && !late_hit && !mac_ctrl0_r[7] && attempts_r == 5'h0
    |=> slot_cnt_r == ($past(lfsr_def_r[9:0]) & 10'h001))
    else $error("Default back-off not used");
  excess_drop_a: assert property (@(posedge clk) disable iff (rst)
    col_hit && !late_hit && attempts_r == 5'hF && !coll_ctrl_r[0] |=> tx_drop_r ##1 !tx_drop_r)
    else $error("Excessive collision not dropped");
  full_dup_a: assert property (@(posedge clk) disable iff (rst)
    ce && !half_duplex && tx_st_r == SPMHD_TX_XMIT |=> !tx_abort_r)
    else $error("Collision acted on in full duplex");
  len_drop_a: assert property (@(posedge clk) disable iff (rst)
    eop_acc && !pop && cnt_r == 2'h0 && mac_ctrl0_r[3] && is_len && meas != expect_len
    |=> verd_valid_r && verd_data_r[11])
    else $error("Length mismatch frame not dropped");
  type_pass_a: assert property (@(posedge clk) disable iff (rst)
    eop_acc && !pop && cnt_r == 2'h0 && !is_len |=> verd_valid_r && !verd_data_r[11])
    else $error("Type field frame dropped");
  tail_excl_a: assert property (@(posedge clk) disable iff (rst)
    eop_acc && !pop && cnt_r == 2'h0 && tail_tag_en
    |=> verd_data_r[10:0] == $past(total) - 11'h013)
    else $error("Tail tag not excluded from length");
  late_seen_c: cover property (@(posedge clk) disable iff (rst) late_hit);
  backoff_retry_c: cover property (@(posedge clk) disable iff (rst)
    tx_st_r == SPMHD_TX_BACKOFF ##[1:600] tx_st_r == SPMHD_TX_XMIT);
  buf_full_c: cover property (@(posedge clk) disable iff (rst) cnt_r == 2'h2 && !rx_ready_r);
  len_drop_c: cover property (@(posedge clk) disable iff (rst) verd_valid_r && verd_data_r[11]);
endmodule // spmhd_port
`default_nettype wire

// File: tb/spmhd_link_model.sv
// Link partner model: free bit clock, frame end and commanded collisions
`default_nettype none
module spmhd_link_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Attempt state seen from the port
  input wire logic tx_active_r,
  // Collision point in ticks, zero for none
  input wire logic [11:0] coll_at,
  // Toward the port
  output logic bit_tick,
  output logic tx_done,
  output logic col_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FRAME_TICKS = 700;
  logic [11:0] cnt_r;
  logic spent_r;
  // One tick a cycle; only the first attempt of a frame is hit, so retries finish
  always_ff @(posedge clk) begin
    bit_tick <= !rst;
    cnt_r <= tx_active_r ? cnt_r + 12'h001 : 12'h000;
    tx_done <= tx_active_r && cnt_r == 12'(FRAME_TICKS);
    col_pin <= tx_active_r && !spent_r && coll_at != 12'h000 && cnt_r >= coll_at;
    if (coll_at == 12'h000) begin
      spent_r <= 1'b0;
    end else if (col_pin && !tx_active_r) begin
      spent_r <= 1'b1;
    end
  end
endmodule : spmhd_link_model
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the switch port half-duplex control block
`include "spmhd_defs.svh"
`default_nettype none
module tb;
  import spmhd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic rst = 1;
  logic ce = 1;
  logic mgmt_wr = 0;
  logic mgmt_rd = 0;
  logic mgmt_mib = 0;
  spmhd_src_e mgmt_src = SPMHD_SRC_SPI;
  logic [15:0] mgmt_addr = 16'h0000;
  logic [7:0] mgmt_wdata = 8'h00;
  logic half_duplex = 1;
  logic tail_tag_en = 0;
  logic tx_req = 0;
  logic rx_valid = 0;
  logic [7:0] rx_data = 8'h00;
  logic rx_sop = 0;
  logic rx_eop = 0;
  logic verd_ready = 0;
  logic [11:0] coll_at = 12'h000;
  logic [15:0] mgmt_rdata_r;
  logic mgmt_rvalid_r, mgmt_refused_r, tx_active_r, tx_abort_r, tx_drop_r, tx_ok_r;
  logic rx_ready_r, verd_valid_r, bit_tick, tx_done, col_pin;
  spmhd_verd_t verd_data_r;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;

  spmhd_port u_dut (.clk, .rst, .ce, .mgmt_wr, .mgmt_rd, .mgmt_mib, .mgmt_src, .mgmt_addr,
    .mgmt_wdata, .mgmt_rdata_r, .mgmt_rvalid_r, .mgmt_refused_r, .half_duplex, .tail_tag_en,
    .tx_req, .tx_done, .bit_tick, .col_pin, .tx_active_r, .tx_abort_r, .tx_drop_r, .tx_ok_r,
    .rx_valid, .rx_data, .rx_sop, .rx_eop, .rx_ready_r, .verd_valid_r, .verd_data_r,
    .verd_ready);
  spmhd_link_model u_link (.clk, .rst, .tx_active_r, .coll_at, .bit_tick, .tx_done, .col_pin);

  // Clock and hang guard
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One register access; flag is read valid or write refused
  task automatic acc(input logic rd, input logic mib, input spmhd_src_e src,
      input logic [15:0] addr, input logic [7:0] wd, output logic flag);
    mgmt_rd = rd;
    mgmt_wr = !rd;
    mgmt_mib = mib;
    mgmt_src = src;
    mgmt_addr = addr;
    mgmt_wdata = wd;
    @(negedge clk);
    flag = rd ? mgmt_rvalid_r : mgmt_refused_r; // Pulse stands this cycle only
    mgmt_rd = 0;
    mgmt_wr = 0;
    @(negedge clk);
  endtask

  task automatic rd_chk(input logic mib, input logic [15:0] addr, input logic [15:0] exp);
    logic f;
    acc(1, mib, SPMHD_SRC_SPI, addr, 8'h00, f);
    chk(f, 16'h0001);
    chk(mgmt_rdata_r, exp);
  endtask

  task automatic t_regs();
    logic f;
    rd_chk(0, `SPMHD_COLL_CTRL_ADDR, 16'h0000);
    rd_chk(0, `SPMHD_MAC_CTRL0_ADDR, 16'h0000);
    rd_chk(0, 16'h0123, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      acc(0, 0, spmhd_src_e'(s), `SPMHD_MAC_CTRL0_ADDR, 8'h80 | 8'(s), f);
      chk(f, {15'h0000, s == 3});
      rd_chk(0, `SPMHD_MAC_CTRL0_ADDR, 16'h0080 | 16'(s == 3 ? 2 : s));
    end
    acc(0, 0, SPMHD_SRC_I2C, `SPMHD_COLL_CTRL_ADDR, 8'h01, f);
    rd_chk(0, `SPMHD_COLL_CTRL_ADDR, 16'h0001);
    // A write while the block is frozen must not land
    ce = 0;
    acc(0, 0, SPMHD_SRC_SPI, `SPMHD_COLL_CTRL_ADDR, 8'h00, f);
    ce = 1;
    chk(f, 16'h0000);
    rd_chk(0, `SPMHD_COLL_CTRL_ADDR, 16'h0001);
    $display("test regs done");
  endtask

  // One frame, through its retries until sent or dropped, with an optional collision point
  task automatic tx_run(input logic [11:0] at, input logic ab, input logic dr);
    logic seen_ab = 0;
    int n = 0;
    coll_at = at;
    tx_req = 1;
    while (tx_ok_r !== 1 && tx_drop_r !== 1 && n < 5000) begin
      @(negedge clk);
      n++;
      if (tx_abort_r === 1) seen_ab = 1;
    end
    tx_req = 0;
    coll_at = 12'h000;
    chk(seen_ab, ab);
    chk(tx_drop_r, dr);
    chk(tx_ok_r, !dr);
    chk(tx_active_r, 16'h0000);
    @(negedge clk);
  endtask

  task automatic t_tx();
    logic f;
    tx_run(12'h000, 0, 0);
    tx_run(12'h064, 1, 0);
    // Same early collision with the default back-off sequence
    acc(0, 0, SPMHD_SRC_SPI, `SPMHD_MAC_CTRL0_ADDR, 8'h00, f);
    chk(f, 16'h0000);
    tx_run(12'h064, 1, 0);
    rd_chk(1, `SPMHD_MIB_LATE_COL_IDX, 16'h0000);
    tx_run(12'h258, 0, 1);
    rd_chk(1, `SPMHD_MIB_LATE_COL_IDX, 16'h0001);
    half_duplex = 0;
    tx_run(12'h064, 0, 0);
    rd_chk(1, `SPMHD_MIB_LATE_COL_IDX, 16'h0001);
    $display("test transmit done");
  endtask

  // Frame with 46 data bytes and the given length or type field
  task automatic send_frame(input logic [15:0] field, input logic tt);
    int nb = 64 + tt;
    for (int i = 0; i < nb; i++) begin
      while (rx_ready_r !== 1) @(negedge clk);
      rx_valid = 1;
      rx_sop = (i == 0);
      rx_eop = (i == nb - 1);
      rx_data = i == 12 ? field[15:8] : i == 13 ? field[7:0] : 8'(i);
      @(negedge clk);
    end
    rx_valid = 0;
    rx_sop = 0;
    rx_eop = 0;
    rx_data = ~rx_data;
    @(negedge clk);
  endtask

  task automatic pop(input logic [11:0] exp);
    int n = 0;
    while (verd_valid_r !== 1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(verd_valid_r, 16'h0001);
    chk(verd_data_r, exp);
    verd_ready = 1;
    @(negedge clk);
    verd_ready = 0;
    @(negedge clk);
  endtask

  task automatic t_len();
    logic f;
    logic [15:0] fld [6] = '{16'h002E, 16'h0032, 16'h0800, 16'h000A, 16'h002E, 16'h0032};
    logic [11:0] ev [6] = '{12'h02E, 12'h82E, 12'h02E, 12'h02E, 12'h02E, 12'h02E};
    acc(0, 0, SPMHD_SRC_INBAND, `SPMHD_MAC_CTRL0_ADDR, 8'h88, f);
    for (int i = 0; i < 6; i++) begin
      if (i == 5) acc(0, 0, SPMHD_SRC_SPI, `SPMHD_MAC_CTRL0_ADDR, 8'h80, f);
      tail_tag_en = (i == 4);
      send_frame(fld[i], i == 4);
      pop(ev[i]);
    end
    $display("test length check done");
  endtask

  task automatic t_buf();
    logic f;
    acc(0, 0, SPMHD_SRC_SPI, `SPMHD_MAC_CTRL0_ADDR, 8'h88, f);
    send_frame(16'h002E, 0);
    send_frame(16'h0032, 0);
    repeat (2) @(negedge clk);
    chk(rx_ready_r, 16'h0000);
    pop(12'h02E);
    pop(12'h82E);
    @(negedge clk);
    chk(rx_ready_r, 16'h0001);
    $display("test buffer done");
  endtask

  // Main sequence
  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    repeat (2) @(negedge clk);
    t_regs();
    t_tx();
    t_len();
    t_buf();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
